/* File: design/ppe_ee_array.sv */
// Data EEPROM array with one write port and a registered read port
`timescale 1ns/1ps

module ppe_ee_array #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Contents are nonvolatile, so no reset; read lags address by one edge
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : ppe_ee_array

/* File: design/ppe_params.svh */
// Constants of the parallel-programming EEPROM, fuse and lock handler
`ifndef PPE_PARAMS_SVH
`define PPE_PARAMS_SVH

// Command codes taken by the load step
`define PPE_CMD_EE_WRITE 8'h11
`define PPE_CMD_EE_READ 8'h03
`define PPE_CMD_FUSE_WRITE 8'h40
`define PPE_CMD_LOCK_WRITE 8'h20
`define PPE_CMD_FUSE_READ 8'h04

// Kinds of load step selected on the load-kind pins
`define PPE_LOAD_ADDR 2'h0
`define PPE_LOAD_DATA 2'h1
`define PPE_LOAD_CMD 2'h2

// Bit positions in the written data byte
`define PPE_FUSE_SERIAL_PROG_ENABLE_FUSE_POS 5
`define PPE_FUSE_RC_OSC_SELECT_FUSE_POS 0
`define PPE_LOCK2_POS 2
`define PPE_LOCK1_POS 1

// Bit positions in the status byte, reserved bits read as one
`define PPE_STAT_LOCK1_POS 7
`define PPE_STAT_LOCK2_POS 6
`define PPE_STAT_SERIAL_PROG_ENABLE_FUSE_POS 5
`define PPE_STAT_RC_OSC_SELECT_FUSE_POS 0
`define PPE_STAT_RSVD 8'h1E

// Reset values of the nonvolatile bits, one is unprogrammed
`define PPE_RST_SERIAL_PROG_ENABLE_FUSE 1'h1
`define PPE_RST_RC_OSC_SELECT_FUSE 1'h1
`define PPE_RST_LOCK 1'h1

// APB register offsets and reset values
`define PPE_OFS_CTRL 32'h0000_0000
`define PPE_OFS_STATUS 32'h0000_0004
`define PPE_RST_CTRL_EN 1'h1

// Timing: clock rate and least EEPROM or lock write busy time
`define PPE_CLK_MHZ 10
`define PPE_WRITE_BUSY_US 500
`define PPE_WRITE_BUSY_CYC (`PPE_WRITE_BUSY_US * `PPE_CLK_MHZ)

`endif

/* File: design/ppe_pkg.sv */
// Types of the parallel-programming EEPROM, fuse and lock handler
package ppe_pkg;

  // Handler state, one-hot
  typedef enum logic [1:0] {
    PPE_ST_IDLE = 2'h1,
    PPE_ST_BUSY = 2'h2
  } ppe_state_e;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } ppe_apb_req_s;

  // APB answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ppe_apb_rsp_s;

  // Whole state of the handler
  typedef struct packed {
    ppe_state_e fsm;
    logic [15:0] busy_cnt;
    logic [7:0] cmd;
    logic [7:0] addr;
    logic [7:0] data;
    logic serial_prog_enable_fuse;
    logic rc_osc_select_fuse;
    logic lock1;
    logic lock2;
    logic ctrl_en;
    logic [2:0] wr_n_sy;
    logic [2:0] stb_sy;
    logic [1:0] oe_n_sy;
    logic [1:0] bs_sy;
    logic [1:0] kind_sy0;
    logic [1:0] kind_sy1;
    logic [7:0] din_sy0;
    logic [7:0] din_sy1;
    logic data_oe;
    logic [7:0] data_out;
    logic [31:0] prdata;
    logic perr;
  } ppe_state_s;

endpackage : ppe_pkg

/* File: design/ppe_prog_ctrl.sv */
// Parallel-programming handler for data EEPROM, fuse bits and lock bits
//
// Overview of operation
// - Command 0x11, address, data, then write strobe stores byte in EEPROM.
// - Command 0x03, address, then output enable and byte select low reads EEPROM.
// - Command 0x40 and data byte; zero programs a fuse, one erases it.
// - Fuse byte: bit 5 serial-enable fuse, bit 0 RC-select fuse, reserved ones.
// - One low write strobe pulse executes the fuse programming.
// - Fuse programming leaves the ready/busy pin unchanged.
// - Command 0x20, data byte, write strobe programs lock bits given as zero.
// - Lock byte: bit 2 is lock 2, bit 1 is lock 1, zero programs.
// - Lock bits return to unprogrammed only through chip erase; here SYS_RST also loads them unprogrammed.
// - Command 0x04, output enable low, byte select high reads fuse/lock status.
// - Status byte: lock1 bit 7, lock2 bit 6, serial fuse bit 5, RC fuse bit 0.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "ppe_params.svh"

module ppe_prog_ctrl #(
  parameter int AW = 6,
  parameter int BUSY_CYCLES = `PPE_WRITE_BUSY_CYC
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PROG_MODE,
  input wire logic CHIP_ERASE,
  input wire logic LOAD_STB,
  input wire logic [1:0] LOAD_KIND,
  input wire logic WR_N,
  input wire logic OE_N,
  input wire logic BYTE_HALF_SELECT,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  output logic READY_BUSY_PIN,
  output logic SERIAL_PROG_ENABLE_FUSE,
  output logic RC_OSC_SELECT_FUSE,
  output logic [1:0] LOCK_BITS,
  input wire ppe_pkg::ppe_apb_req_s APB_REQ,
  output ppe_pkg::ppe_apb_rsp_s APB_RSP
);
  import ppe_pkg::*;

  ppe_state_s st_ff;
  ppe_state_s nxt_st;
  logic [7:0] ee_rdata;
  logic ee_we;
  logic active;
  logic wr_fall;
  logic stb_rise;
  logic [7:0] stat_byte;

  // Status byte in the order the programmer reads it, zero means programmed
  function automatic logic [7:0] fuse_status(input ppe_state_s s);
    logic [7:0] b;
    b = `PPE_STAT_RSVD;
    b[`PPE_STAT_LOCK1_POS] = s.lock1;
    b[`PPE_STAT_LOCK2_POS] = s.lock2;
    b[`PPE_STAT_SERIAL_PROG_ENABLE_FUSE_POS] = s.serial_prog_enable_fuse;
    b[`PPE_STAT_RC_OSC_SELECT_FUSE_POS] = s.rc_osc_select_fuse;
    return b;
  endfunction : fuse_status

  // EEPROM array, written only by the write-strobe step
  ppe_ee_array #(
    .AW(AW),
    .DW(8)
  ) ppe_ee_array_i (
    .clk(CLK),
    .we(ee_we),
    .waddr(st_ff.addr[AW-1:0]),
    .wdata(st_ff.data),
    .raddr(st_ff.addr[AW-1:0]),
    .rdata(ee_rdata)
  );

  // Edges seen on the second synchroniser stage only
  assign wr_fall = st_ff.wr_n_sy[2] & ~st_ff.wr_n_sy[1];
  assign stb_rise = st_ff.stb_sy[1] & ~st_ff.stb_sy[2];
  assign active = PROG_MODE & st_ff.ctrl_en;
  assign stat_byte = fuse_status(st_ff);

  // Next-state logic for pins, commands, writes, reads and APB
  always_comb
  begin
    nxt_st = st_ff;
    ee_we = 1'b0;

    // Two-flop synchronisers for every pin except PROG_MODE and CHIP_ERASE; stage 0 feeds stage 1 only
    nxt_st.wr_n_sy = {st_ff.wr_n_sy[1:0], WR_N};
    nxt_st.stb_sy = {st_ff.stb_sy[1:0], LOAD_STB};
    nxt_st.oe_n_sy = {st_ff.oe_n_sy[0], OE_N};
    nxt_st.bs_sy = {st_ff.bs_sy[0], BYTE_HALF_SELECT};
    nxt_st.kind_sy0 = LOAD_KIND;
    nxt_st.kind_sy1 = st_ff.kind_sy0;
    nxt_st.din_sy0 = DATA_IN;
    nxt_st.din_sy1 = st_ff.din_sy0;

    // Load steps: command, address low byte or data low byte
    if (active && stb_rise)
    begin
      case (st_ff.kind_sy1)
        `PPE_LOAD_CMD: nxt_st.cmd = st_ff.din_sy1;
        `PPE_LOAD_ADDR: nxt_st.addr = st_ff.din_sy1;
        `PPE_LOAD_DATA: nxt_st.data = st_ff.din_sy1;
        default: nxt_st.data = st_ff.data;
      endcase
    end

    // Write strobe: ignored while a timed write is still running
    case (st_ff.fsm)
      PPE_ST_IDLE:
      begin
        if (active && wr_fall)
        begin
          if (st_ff.cmd == `PPE_CMD_EE_WRITE)
          begin
            ee_we = 1'b1;
            nxt_st.fsm = PPE_ST_BUSY;
            nxt_st.busy_cnt = 16'(BUSY_CYCLES - 1);
          end
          else if (st_ff.cmd == `PPE_CMD_FUSE_WRITE)
          begin
            nxt_st.serial_prog_enable_fuse = st_ff.data[`PPE_FUSE_SERIAL_PROG_ENABLE_FUSE_POS];
            nxt_st.rc_osc_select_fuse = st_ff.data[`PPE_FUSE_RC_OSC_SELECT_FUSE_POS];
          end
          // AND keeps a programmed bit programmed
          else if (st_ff.cmd == `PPE_CMD_LOCK_WRITE)
          begin
            nxt_st.lock1 = st_ff.lock1 & st_ff.data[`PPE_LOCK1_POS];
            nxt_st.lock2 = st_ff.lock2 & st_ff.data[`PPE_LOCK2_POS];
            nxt_st.fsm = PPE_ST_BUSY;
            nxt_st.busy_cnt = 16'(BUSY_CYCLES - 1);
          end
        end
      end
      PPE_ST_BUSY:
      begin
        // Write time runs out on its own, strobe edges are dropped
        if (st_ff.busy_cnt == 16'h0000)
        begin
          nxt_st.fsm = PPE_ST_IDLE;
        end
        else
        begin
          nxt_st.busy_cnt = st_ff.busy_cnt - 16'h0001;
        end
      end
      default:
      begin
        nxt_st.fsm = PPE_ST_IDLE;
      end
    endcase

    // chip erase and SYS_RST are the only ways back; erase wins over a lock write
    if (CHIP_ERASE)
    begin
      nxt_st.lock1 = `PPE_RST_LOCK;
      nxt_st.lock2 = `PPE_RST_LOCK;
    end

    // drive only while output enable is low and a read fits
    nxt_st.data_oe = 1'b0;
    nxt_st.data_out = st_ff.data_out;
    if (active && !st_ff.oe_n_sy[1])
    begin
      // EEPROM read with byte select low
      if (st_ff.cmd == `PPE_CMD_EE_READ && !st_ff.bs_sy[1])
      begin
        nxt_st.data_oe = 1'b1;
        nxt_st.data_out = ee_rdata;
      end
      // status read with byte select high
      else if (st_ff.cmd == `PPE_CMD_FUSE_READ && st_ff.bs_sy[1])
      begin
        nxt_st.data_oe = 1'b1;
        nxt_st.data_out = stat_byte;
      end
    end

    // APB setup phase decodes and captures read data for the access phase
    if (APB_REQ.psel && !APB_REQ.penable)
    begin
      nxt_st.perr = 1'b0;
      if (APB_REQ.paddr == `PPE_OFS_CTRL)
      begin
        nxt_st.prdata = {31'h0, st_ff.ctrl_en};
      end
      else if (APB_REQ.paddr == `PPE_OFS_STATUS)
      begin
        nxt_st.prdata = {15'h0, (st_ff.fsm == PPE_ST_IDLE), st_ff.cmd, stat_byte};
      end
      else
      begin
        nxt_st.prdata = 32'h0;
        nxt_st.perr = 1'b1;
      end
    end

    // APB write takes effect at the access edge
    if (APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite &&
        APB_REQ.paddr == `PPE_OFS_CTRL)
    begin
      nxt_st.ctrl_en = APB_REQ.pwdata[0];
    end
  end

  // State register with synchronous reset
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      st_ff <= '0;
      st_ff.fsm <= PPE_ST_IDLE;
      st_ff.serial_prog_enable_fuse <= `PPE_RST_SERIAL_PROG_ENABLE_FUSE;
      st_ff.rc_osc_select_fuse <= `PPE_RST_RC_OSC_SELECT_FUSE;
      st_ff.lock1 <= `PPE_RST_LOCK;
      st_ff.lock2 <= `PPE_RST_LOCK;
      st_ff.ctrl_en <= `PPE_RST_CTRL_EN;
      st_ff.wr_n_sy <= 3'h7; // Idle strobe is high, no false edge
      st_ff.oe_n_sy <= 2'h3;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flops except pslverr, gated by the live request; pready is a constant zero-wait answer
  assign DATA_OUT = st_ff.data_out;
  assign DATA_OE = st_ff.data_oe;
  assign READY_BUSY_PIN = (st_ff.fsm == PPE_ST_IDLE);
  assign SERIAL_PROG_ENABLE_FUSE = st_ff.serial_prog_enable_fuse;
  assign RC_OSC_SELECT_FUSE = st_ff.rc_osc_select_fuse;
  assign LOCK_BITS = {st_ff.lock2, st_ff.lock1};
  assign APB_RSP.prdata = st_ff.prdata;
  assign APB_RSP.pready = 1'b1;
  assign APB_RSP.pslverr = APB_REQ.psel & APB_REQ.penable & st_ff.perr;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // Written byte readable two edges later at the same address
  a_ee_write_lands: assert property (
    (ee_we ##1 $stable(st_ff.addr)) |=> (ee_rdata == $past(st_ff.data, 2)))
    else $error("EEPROM byte not stored");

  a_ee_read_data: assert property (
    (DATA_OE && st_ff.cmd == `PPE_CMD_EE_READ) |-> (DATA_OUT == $past(ee_rdata)))
    else $error("EEPROM read data wrong");

  a_fuse_value_taken: assert property (
    (active && wr_fall && st_ff.fsm == PPE_ST_IDLE && st_ff.cmd == `PPE_CMD_FUSE_WRITE
      && !SYS_RST) |=> (SERIAL_PROG_ENABLE_FUSE == $past(st_ff.data[5])
      && RC_OSC_SELECT_FUSE == $past(st_ff.data[0])))
    else $error("fuse bits not taken from data byte");

  a_fuse_only_strobe: assert property (
    ($changed(st_ff.serial_prog_enable_fuse) || $changed(st_ff.rc_osc_select_fuse)) |->
      $past(wr_fall && st_ff.cmd == `PPE_CMD_FUSE_WRITE))
    else $error("fuse changed without write strobe");

  a_fuse_no_busy: assert property (
    (st_ff.fsm == PPE_ST_IDLE && wr_fall && st_ff.cmd == `PPE_CMD_FUSE_WRITE) |=>
      $stable(READY_BUSY_PIN)[*2])
    else $error("ready/busy moved on fuse write");

  a_lock_and_data: assert property (
    (active && wr_fall && st_ff.fsm == PPE_ST_IDLE && st_ff.cmd == `PPE_CMD_LOCK_WRITE
      && !CHIP_ERASE) |=> (LOCK_BITS == ($past(LOCK_BITS) & $past(st_ff.data[2:1]))
      && !READY_BUSY_PIN))
    else $error("lock bits not programmed from data");

  a_lock_no_clear: assert property (
    ($rose(st_ff.lock1) || $rose(st_ff.lock2)) |-> $past(CHIP_ERASE))
    else $error("lock bit cleared without chip erase");

  a_status_byte: assert property (
    (DATA_OE && st_ff.cmd == `PPE_CMD_FUSE_READ) |->
      (DATA_OUT == {$past(st_ff.lock1), $past(st_ff.lock2), $past(st_ff.serial_prog_enable_fuse),
      4'hF, $past(st_ff.rc_osc_select_fuse)}))
    else $error("status byte layout wrong");

  a_bus_release: assert property (
    (st_ff.oe_n_sy[1] || !active) |=> !DATA_OE)
    else $error("data bus driven with output enable high");

  // Command byte latched by its load step
  a_load_cmd_taken: assert property (
    (active && stb_rise && st_ff.kind_sy1 == `PPE_LOAD_CMD) |=>
      (st_ff.cmd == $past(st_ff.din_sy1)))
    else $error("command byte not latched");

  // Timed write always ends in ready
  a_busy_ends: assert property (
    (st_ff.fsm == PPE_ST_BUSY && st_ff.busy_cnt == 16'h0000) |=> READY_BUSY_PIN)
    else $error("busy phase did not end");

  // Strobe during a timed write is dropped
  a_busy_drops_strobe: assert property (
    (st_ff.fsm == PPE_ST_BUSY && wr_fall && !CHIP_ERASE) |=>
      ($stable(LOCK_BITS) && $stable(SERIAL_PROG_ENABLE_FUSE)))
    else $error("strobe taken while busy");

  // Status byte needs byte select high
  a_status_needs_bs: assert property (
    (st_ff.cmd == `PPE_CMD_FUSE_READ && !st_ff.bs_sy[1]) |=> !DATA_OE)
    else $error("status driven with byte select low");

endmodule : ppe_prog_ctrl

/* File: testbench/ppe_prog_model.sv */
// Parallel programmer model driving load, strobe and read pins
`timescale 1ns/1ps

module ppe_prog_model (
  input wire logic clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic load_stb,
  output logic [1:0] load_kind,
  output logic wr_n,
  output logic oe_n,
  output logic bs,
  output logic [7:0] din
);
  // Idle pins, strobes inactive
  initial
  begin
    load_stb = 1'h0;
    load_kind = 2'h3;
    wr_n = 1'h1;
    oe_n = 1'h1;
    bs = 1'h0;
    din = 8'hA5;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  // load step; pins steady three clocks before and while the strobe is high
  task automatic load(input logic [1:0] k, input logic [7:0] d);
    load_kind <= k;
    din <= d;
    hold(3);
    load_stb <= 1'h1;
    hold(3);
    load_stb <= 1'h0;
    din <= ~d;
    hold(3);
  endtask : load

  // single low write pulse of the given width
  task automatic strobe(input int n);
    wr_n <= 1'h0;
    hold(n);
    wr_n <= 1'h1;
    hold(3);
  endtask : strobe

  // output enable low, byte select picks the source
  task automatic read(input logic b, output logic [7:0] d);
    bs <= b;
    hold(3);
    oe_n <= 1'h0;
    hold(6);
    // Undriven bus shows the inverse of the last byte
    d = data_oe ? data_out : ~data_out;
    oe_n <= 1'h1;
    hold(6);
  endtask : read
endmodule : ppe_prog_model

/* File: testbench/tb_ppe_prog_ctrl.sv */
// Self-checking bench of the parallel-programming handler
`timescale 1ns/1ps
`include "ppe_params.svh"

module tb_ppe_prog_ctrl;
  import ppe_pkg::*;
  logic clk, sys_rst, erase, stb, wr_n, oe_n, bs, doe, rdy, serial_prog_enable_fuse, rc_osc_select_fuse;
  logic [1:0] kind, lk, locks;
  logic [7:0] din, dout, rd, f;
  logic [7:0] mem [64];
  logic [5:0] a [4];
  logic [31:0] r;
  logic e;
  ppe_apb_req_s req;
  ppe_apb_rsp_s rsp;
  int error_cnt, num_checks;
  int w [2] = '{10000, 18000};
  logic [7:0] ld [3] = '{8'hFD, 8'hFF, 8'hF9};

  ppe_prog_ctrl #(.BUSY_CYCLES(20)) ppe_prog_ctrl_i (.CLK(clk), .SYS_RST(sys_rst),
    .PROG_MODE(1'h1), .CHIP_ERASE(erase), .LOAD_STB(stb), .LOAD_KIND(kind), .WR_N(wr_n),
    .OE_N(oe_n), .BYTE_HALF_SELECT(bs), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe),
    .READY_BUSY_PIN(rdy), .SERIAL_PROG_ENABLE_FUSE(serial_prog_enable_fuse), .RC_OSC_SELECT_FUSE(rc_osc_select_fuse),
    .LOCK_BITS(locks), .APB_REQ(req), .APB_RSP(rsp));
  ppe_prog_model ppe_prog_model_i (.clk(clk), .data_out(dout), .data_oe(doe), .load_stb(stb),
    .load_kind(kind), .wr_n(wr_n), .oe_n(oe_n), .bs(bs), .din(din));

  // Free-running 10 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x)
    begin
      error_cnt++;
      $display("ERROR t=%0t got %0h exp %0h", $time, g, x);
    end
  endtask : chk

  // Bounded wait; a stuck busy flag would otherwise hang the run
  task automatic wait_ready();
    int k;
    k = 0;
    while (rdy !== 1'h1 && k < 100)
    begin
      @(posedge clk);
      k++;
    end
    if (rdy !== 1'h1)
    begin
      error_cnt++;
      conclude();
    end
  endtask : wait_ready

  // APB transfer, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
    int k;
    req <= '{1'h1, 1'h0, wr, ad, wd};
    @(posedge clk);
    req.penable <= 1'h1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'h1 && k < 100);
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    // Idle edge so a following call never reassigns the request in this step
    @(posedge clk);
    if (rsp.pready !== 1'h1)
    begin
      error_cnt++;
      conclude();
    end
  endtask : apb

  function automatic logic [7:0] stat(input logic [1:0] l, input logic [7:0] fb);
    return {l[0], l[1], fb[5], 4'hF, fb[0]};
  endfunction : stat

  // Main sequence
  initial
  begin
    sys_rst = 1'h1;
    erase = 1'h0;
    req = '0;
    error_cnt = 0;
    num_checks = 0;
    lk = 2'h3;
    void'($urandom(32'h983E409C));
    repeat (5) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    chk({rdy, serial_prog_enable_fuse, rc_osc_select_fuse, locks, doe}, 6'h3E);
    apb(1'h1, `PPE_OFS_CTRL, 32'h1);
    chk(e, 1'h0);
    apb(1'h0, 32'h8, 32'h0);
    chk({e, r}, {1'h1, 32'h0});
    // Random EEPROM bytes, top address first
    for (int i = 0; i < 4; i++)
    begin
      a[i] = (i == 0) ? 6'h3F : 6'($urandom);
      mem[a[i]] = 8'($urandom);
      ppe_prog_model_i.load(`PPE_LOAD_CMD, `PPE_CMD_EE_WRITE);
      ppe_prog_model_i.load(`PPE_LOAD_ADDR, {2'h0, a[i]});
      ppe_prog_model_i.load(`PPE_LOAD_DATA, mem[a[i]]);
      ppe_prog_model_i.strobe(3);
      chk(rdy, 1'h0);
      wait_ready();
    end
    for (int i = 0; i < 4; i++)
    begin
      ppe_prog_model_i.load(`PPE_LOAD_CMD, `PPE_CMD_EE_READ);
      ppe_prog_model_i.load(`PPE_LOAD_ADDR, {2'h0, a[i]});
      ppe_prog_model_i.read(1'h0, rd);
      chk(rd, mem[a[i]]);
      chk(doe, 1'h0);
    end
    // Fuses at the shortest and longest pulse; busy flag must stay high
    for (int i = 0; i < 2; i++)
    begin
      f = (i == 0) ? 8'hDE : (8'($urandom) | 8'hDE);
      ppe_prog_model_i.load(`PPE_LOAD_CMD, `PPE_CMD_FUSE_WRITE);
      ppe_prog_model_i.load(`PPE_LOAD_DATA, f);
      fork
        ppe_prog_model_i.strobe(w[i]);
        begin
          repeat (w[i] / 2) @(posedge clk);
          chk(rdy, 1'h1);
        end
      join
      chk({serial_prog_enable_fuse, rc_osc_select_fuse}, {f[5], f[0]});
    end
    // Handler disabled over APB: loads and strobe must be dropped
    apb(1'h1, `PPE_OFS_CTRL, 32'h0);
    apb(1'h0, `PPE_OFS_CTRL, 32'h0);
    chk(r, 32'h0);
    ppe_prog_model_i.load(`PPE_LOAD_CMD, `PPE_CMD_LOCK_WRITE);
    ppe_prog_model_i.load(`PPE_LOAD_DATA, 8'hF9);
    ppe_prog_model_i.strobe(3);
    chk({rdy, locks}, 3'h7);
    apb(1'h1, `PPE_OFS_CTRL, 32'h1);
    apb(1'h0, `PPE_OFS_CTRL, 32'h0);
    chk(r, 32'h1);
    // Locks: program one, rewrite ones, then program the other
    for (int i = 0; i < 3; i++)
    begin
      lk = lk & ld[i][2:1];
      ppe_prog_model_i.load(`PPE_LOAD_CMD, `PPE_CMD_LOCK_WRITE);
      ppe_prog_model_i.load(`PPE_LOAD_DATA, ld[i]);
      ppe_prog_model_i.strobe(3);
      ppe_prog_model_i.strobe(3);
      wait_ready();
      chk(locks, lk);
      ppe_prog_model_i.load(`PPE_LOAD_CMD, `PPE_CMD_FUSE_READ);
      ppe_prog_model_i.read(1'h1, rd);
      chk(rd, stat(lk, f));
    end
    apb(1'h0, `PPE_OFS_STATUS, 32'h0);
    chk(r, {15'h0, 1'h1, `PPE_CMD_FUSE_READ, stat(lk, f)});
    erase <= 1'h1;
    @(posedge clk);
    erase <= 1'h0;
    repeat (2) @(posedge clk);
    chk(locks, 2'h3);
    conclude();
  end
endmodule : tb_ppe_prog_ctrl
